/* mfp_board.sv */
// Purpose: host bus and board model on the shared pin side
// Assumes: device pins resolve against the board's own drivers
// Notes:   the board yields any lane the device is driving
`timescale 1ns/1ps
`default_nettype none

module mfp_board
(
  input  wire logic [3:0] dev_pin_i,
  input  wire logic [3:0] dev_oe_i,
  input  wire logic       dev_st_i,
  input  wire logic       dev_st_oe_i,
  input  wire logic [3:0] board_i,
  input  wire logic       board_st_i,
  output var  logic [3:0] level_o,
  output var  logic       st_level_o
);
  // ---------------------------------------------------------------
  // wire resolution
  // ---------------------------------------------------------------
  // contention is not modelled: the host never drives a device output
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      level_o[i] = dev_oe_i[i] ? dev_pin_i[i] : board_i[i];
    end
    st_level_o = dev_st_oe_i ? dev_st_i : board_st_i;
  end
endmodule : mfp_board

`default_nettype wire

/* mfp_pad.sv */
// Purpose: one shared pin driver: input, push-pull or open drain
// Assumes: mode and drive settle one cycle before the pin follows
// Notes:   output and enable come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "mfp_params.svh"

module mfp_pad
(
  input  wire logic                  clock_i,
  input  wire logic                  arst_n_i,
  input  wire mfp_pkg::mfp_pad_mode_e mode_i,
  input  wire logic                  drive_i,
  output var  logic                  pin_o,
  output var  logic                  pin_oe_o
);

  logic pin_next;
  logic oe_next;

  // ---------------------------------------------------------------
  // direction decode
  // ---------------------------------------------------------------
  // open drain never drives high, so it only enables on a low
  always_comb
  begin
    pin_next = 1'b0;
    oe_next  = 1'b0;
    case (mode_i)
      mfp_pkg::MFP_PAD_OUT:
      begin
        pin_next = drive_i;                            // RULE2
        oe_next  = 1'b1;                               // RULE2
      end
      mfp_pkg::MFP_PAD_OD:
      begin
        pin_next = 1'b0;                               // RULE2
        oe_next  = ~drive_i;                           // RULE2
      end
      default:
      begin
        pin_next = 1'b0;                               // RULE2
        oe_next  = 1'b0;                               // RULE2
      end
    endcase
  end

  // registered drive, released to high impedance at reset
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_o    <= `MFP_BIT_RST;
      pin_oe_o <= `MFP_BIT_RST;
    end
    else
    begin
      pin_o    <= pin_next;
      pin_oe_o <= oe_next;
    end
  end

endmodule : mfp_pad

`default_nettype wire

/* mfp_params.svh */
// Purpose: constants for the multi-function pin select block
// Assumes: included by its bare name, definitions only
// Notes:   register field positions follow the register image layout
`ifndef MFP_PARAMS_SVH
`define MFP_PARAMS_SVH

// ---------------------------------------------------------------
// register image layout
// ---------------------------------------------------------------
`define MFP_REG_W        5
`define MFP_GIO_MASK     5'h1d
`define MFP_GIO0_BIT     0
`define MFP_GIO2_BIT     2
`define MFP_GIO3_BIT     3
`define MFP_GIO4_BIT     4

// ---------------------------------------------------------------
// pin lanes (one per shared general i/o pin)
// ---------------------------------------------------------------
`define MFP_LANES        4
`define MFP_LANE_IO0     0
`define MFP_LANE_IO2     1
`define MFP_LANE_IO3     2
`define MFP_LANE_IO4     3

// ---------------------------------------------------------------
// reset values and strap encoding
// ---------------------------------------------------------------
`define MFP_GIO_EN_RST   5'h00
`define MFP_GIO_DATA_RST 5'h00
`define MFP_RDATA_RST    5'h00
`define MFP_LANE_RST     4'h0
`define MFP_FUNC_RST     1'h0
`define MFP_UNMASK_RST   1'h0
`define MFP_BIT_RST      1'h0
`define MFP_STRAP_RST    1'h0
`define MFP_STRAP_ISA    1'h0

`endif

/* mfp_pin_mux.sv */
// Purpose: function select for five shared pins (isa or card bus)
// Assumes: all inputs synchronous to clock_i, register ports are
//          single-cycle write strobes with data
// Notes:   pins follow a register change one cycle after it lands
//
// Operation
// [RULE1] each pin's function comes from the bus strap plus its bits
// [RULE2] input is high impedance, output drives both, open drain pulls low
// [RULE3] data reads return the live pin level, not the written value
// [RULE4] written data and read-back data sit at separate locations
// [RULE5] io2 is the la19 input in isa mode, else enable picks direction
// [RULE6] data bit 2 reads back the io2 pin level always
// [RULE7] io3 is the sa16 input in isa mode, else enable picks direction
// [RULE8] data bit 3 reads back the io3 pin level always
// [RULE9] io4 is the la17 input in isa mode, else enable picks direction
// [RULE10] data bit 4 reads back the io4 pin level always
// [RULE11] io0 is the refresh input in isa mode, else enable picks direction
// [RULE12] data bit 0 reads back the io0 pin level always
// [RULE13] status pin is bale input in isa mode, otherwise always output
// [RULE14] function one with unmask zero keeps the status output deasserted
// [RULE15] writing unmask one lets wakeup reach the status output
// [RULE16] unmask clears by hardware when the wakeup bit clears
// [RULE17] function zero drives the status pin with inverted unmask
// [RULE18] unmask reads back the inverse of the status pin level
// [RULE19] written data bits sit in a latch that keeps driving outputs
`timescale 1ns/1ps
`default_nettype none
`include "mfp_params.svh"

module mfp_pin_mux
(
  input  wire logic                   clock_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   host_bus_type_strap_i,
  input  wire logic                   general_io_enable_we_i,
  input  wire logic [`MFP_REG_W-1:0]  general_io_enable_wdata_i,
  input  wire logic                   general_io_data_we_i,
  input  wire logic [`MFP_REG_W-1:0]  general_io_data_wdata_i,
  input  wire logic                   pin_function_we_i,
  input  wire logic                   status_change_function_select_i,
  input  wire logic                   status_change_unmask_we_i,
  input  wire logic                   status_change_unmask_wdata_i,
  input  wire logic                   card_wakeup_i,
  input  wire logic [`MFP_LANES-1:0]  general_io_pin_i,
  input  wire logic                   status_change_pin_i,
  output var  logic [`MFP_REG_W-1:0]  general_io_enable_o,
  output var  logic [`MFP_REG_W-1:0]  general_io_data_bits_o,
  output var  logic                   status_change_function_select_o,
  output var  logic                   status_change_unmask_o,
  output var  logic [`MFP_LANES-1:0]  general_io_pin_o,
  output var  logic [`MFP_LANES-1:0]  general_io_pin_oe_o,
  output var  logic                   status_change_pin_o,
  output var  logic                   status_change_pin_oe_o,
  output var  logic                   isa_la19_o,
  output var  logic                   isa_sa16_o,
  output var  logic                   isa_la17_o,
  output var  logic                   isa_refresh_o,
  output var  logic                   isa_bale_o
);

  logic                  strap_reg;
  logic                  strap_next;
  logic [`MFP_REG_W-1:0] gio_en_reg;
  logic [`MFP_REG_W-1:0] gio_en_next;
  logic [`MFP_REG_W-1:0] gio_data_reg;
  logic [`MFP_REG_W-1:0] gio_data_next;
  logic                  func_sel_reg;
  logic                  func_sel_next;
  logic [`MFP_REG_W-1:0] rdata_next;
  logic                  unmask_rd_next;
  logic                  card_mode;
  logic [`MFP_LANES-1:0] isa_lane_next;
  logic                  isa_bale_next;
  mfp_pkg::mfp_pad_mode_e stschg_mode;
  logic                  stschg_drive;

  // ---------------------------------------------------------------
  // strap and configuration registers
  // ---------------------------------------------------------------
  // strap resets to isa so every shared pin starts high impedance
  always_comb
  begin
    strap_next    = host_bus_type_strap_i;
    gio_en_next   = gio_en_reg;
    gio_data_next = gio_data_reg;
    func_sel_next = func_sel_reg;
    if (general_io_enable_we_i)
    begin
      gio_en_next = general_io_enable_wdata_i & `MFP_GIO_MASK;
    end
    if (general_io_data_we_i)
    begin
      // output latch, never overwritten by the read-back path
      gio_data_next = general_io_data_wdata_i & `MFP_GIO_MASK; // RULE19
    end
    if (pin_function_we_i)
    begin
      func_sel_next = status_change_function_select_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      strap_reg    <= `MFP_STRAP_RST;
      gio_en_reg   <= `MFP_GIO_EN_RST;
      gio_data_reg <= `MFP_GIO_DATA_RST;
      func_sel_reg <= `MFP_FUNC_RST;
    end
    else
    begin
      strap_reg    <= strap_next;
      gio_en_reg   <= gio_en_next;
      gio_data_reg <= gio_data_next;
      func_sel_reg <= func_sel_next;
    end
  end

  assign card_mode = (strap_reg != `MFP_STRAP_ISA);       // RULE1

  // ---------------------------------------------------------------
  // general i/o pads
  // ---------------------------------------------------------------
  // isa mode forces input whatever the enable bits say
  for (genvar l = 0; l < `MFP_LANES; l++)
  begin : g_gio
    localparam int unsigned BIT = mfp_pkg::mfp_lane_bit(l);
    mfp_pad u_pad
    (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .mode_i   (mfp_pkg::mfp_gio_mode(card_mode,
                                       gio_en_reg[BIT])), // RULE1
      .drive_i  (gio_data_reg[BIT]),                       // RULE19
      .pin_o    (general_io_pin_o[l]),
      .pin_oe_o (general_io_pin_oe_o[l])
    );
  end

  // ---------------------------------------------------------------
  // status-change source and pad
  // ---------------------------------------------------------------
  mfp_stschg u_stschg
  (
    .clock_i        (clock_i),
    .arst_n_i       (arst_n_i),
    .card_mode_i    (card_mode),
    .func_sel_i     (func_sel_reg),
    .unmask_we_i    (status_change_unmask_we_i),
    .unmask_wdata_i (status_change_unmask_wdata_i),
    .wakeup_i       (card_wakeup_i),
    .mode_o         (stschg_mode),
    .drive_o        (stschg_drive)
  );

  mfp_pad u_stschg_pad
  (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .mode_i   (stschg_mode),
    .drive_i  (stschg_drive),
    .pin_o    (status_change_pin_o),
    .pin_oe_o (status_change_pin_oe_o)
  );

  // ---------------------------------------------------------------
  // read-back and isa function paths
  // ---------------------------------------------------------------
  // read-back samples the pin, so an externally driven pin may read
  // differently from the latch; bit 1 is not ours and reads zero
  always_comb
  begin
    rdata_next = `MFP_RDATA_RST;
    rdata_next[`MFP_GIO0_BIT] = general_io_pin_i[`MFP_LANE_IO0]; // RULE12
    rdata_next[`MFP_GIO2_BIT] = general_io_pin_i[`MFP_LANE_IO2]; // RULE6
    rdata_next[`MFP_GIO3_BIT] = general_io_pin_i[`MFP_LANE_IO3]; // RULE8
    rdata_next[`MFP_GIO4_BIT] = general_io_pin_i[`MFP_LANE_IO4]; // RULE10
    unmask_rd_next = ~status_change_pin_i;                    // RULE18
    isa_lane_next  = `MFP_LANE_RST;
    isa_bale_next  = 1'b0;
    if (!card_mode)
    begin
      isa_lane_next = general_io_pin_i;       // RULE5 RULE7 RULE9 RULE11
      isa_bale_next = status_change_pin_i;                    // RULE13
    end
  end

  // separate read and write locations for the data bits
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      general_io_data_bits_o          <= `MFP_RDATA_RST;
      general_io_enable_o             <= `MFP_GIO_EN_RST;
      status_change_function_select_o <= `MFP_FUNC_RST;
      status_change_unmask_o          <= `MFP_BIT_RST;
      isa_la19_o                      <= `MFP_BIT_RST;
      isa_sa16_o                      <= `MFP_BIT_RST;
      isa_la17_o                      <= `MFP_BIT_RST;
      isa_refresh_o                   <= `MFP_BIT_RST;
      isa_bale_o                      <= `MFP_BIT_RST;
    end
    else
    begin
      general_io_data_bits_o          <= rdata_next;          // RULE3 RULE4
      general_io_enable_o             <= gio_en_next;
      status_change_function_select_o <= func_sel_next;
      status_change_unmask_o          <= unmask_rd_next;
      isa_la19_o                      <= isa_lane_next[`MFP_LANE_IO2];
      isa_sa16_o                      <= isa_lane_next[`MFP_LANE_IO3];
      isa_la17_o                      <= isa_lane_next[`MFP_LANE_IO4];
      isa_refresh_o                   <= isa_lane_next[`MFP_LANE_IO0];
      isa_bale_o                      <= isa_bale_next;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_io2_isa_input: assert property ( // RULE5
    !card_mode |=> !general_io_pin_oe_o[`MFP_LANE_IO2])
    else $error("io2 driven in isa mode");

  a_io3_isa_input: assert property ( // RULE7
    !card_mode |=> !general_io_pin_oe_o[`MFP_LANE_IO3])
    else $error("io3 driven in isa mode");

  a_io4_card_dir: assert property ( // RULE9
    card_mode |=> (general_io_pin_oe_o[`MFP_LANE_IO4]
                   == $past(gio_en_reg[`MFP_GIO4_BIT])))
    else $error("io4 direction does not follow enable");

  a_io0_card_dir: assert property ( // RULE11
    card_mode |=> (general_io_pin_oe_o[`MFP_LANE_IO0]
                   == $past(gio_en_reg[`MFP_GIO0_BIT])))
    else $error("io0 direction does not follow enable");

  a_io2_read_live: assert property ( // RULE6
    1'b1 |=> (general_io_data_bits_o[`MFP_GIO2_BIT]
              == $past(general_io_pin_i[`MFP_LANE_IO2])))
    else $error("data bit 2 does not read the pin");

  a_io3_read_live: assert property ( // RULE8
    1'b1 |=> (general_io_data_bits_o[`MFP_GIO3_BIT]
              == $past(general_io_pin_i[`MFP_LANE_IO3])))
    else $error("data bit 3 does not read the pin");

  a_io4_io0_read: assert property ( // RULE10
    1'b1 |=> ((general_io_data_bits_o[`MFP_GIO4_BIT]
               == $past(general_io_pin_i[`MFP_LANE_IO4])) &&
              (general_io_data_bits_o[`MFP_GIO0_BIT]
               == $past(general_io_pin_i[`MFP_LANE_IO0]))))
    else $error("data bit 4 or 0 does not read the pin");

  a_stschg_isa_input: assert property ( // RULE13
    !card_mode |=> !status_change_pin_oe_o ##0
                   (isa_bale_o == $past(status_change_pin_i)))
    else $error("status pin not bale input in isa mode");

  a_stschg_masked: assert property ( // RULE14
    (card_mode && func_sel_reg && !u_stschg.unmask_reg)
      |=> (status_change_pin_oe_o && !status_change_pin_o))
    else $error("status output asserted while masked");

  a_stschg_invert: assert property ( // RULE17
    (card_mode && !func_sel_reg)
      |=> (status_change_pin_o == !$past(u_stschg.unmask_reg)))
    else $error("status output not inverse of unmask");

  a_unmask_read_inv: assert property ( // RULE18
    1'b1 |=> (status_change_unmask_o == !$past(status_change_pin_i)))
    else $error("unmask read is not inverse pin level");

  a_latch_drives_out: assert property ( // RULE19
    (card_mode && gio_en_reg[`MFP_GIO2_BIT])
      |=> (general_io_pin_oe_o[`MFP_LANE_IO2] &&
           general_io_pin_o[`MFP_LANE_IO2]
           == $past(gio_data_reg[`MFP_GIO2_BIT])))
    else $error("io2 output does not follow data latch");

  c_gio_output: cover property (
    card_mode && gio_en_reg[`MFP_GIO3_BIT] ##1
    general_io_pin_oe_o[`MFP_LANE_IO3]);

  c_wakeup_signal: cover property (
    card_mode && func_sel_reg && u_stschg.unmask_reg && card_wakeup_i
    ##1 status_change_pin_o);

  c_isa_to_card: cover property (!card_mode ##1 card_mode);

endmodule : mfp_pin_mux

`default_nettype wire

/* mfp_pkg.sv */
// Purpose: types and shared decode for the multi-function pin select
// Assumes: mfp_params.svh on the include path
// Notes:   strap level 1 selects the card bus, 0 selects isa
package mfp_pkg;
  `include "mfp_params.svh"

  // ---------------------------------------------------------------
  // pad direction modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MFP_PAD_IN  = 2'b00,
    MFP_PAD_OUT = 2'b01,
    MFP_PAD_OD  = 2'b10
  } mfp_pad_mode_e;

  // general i/o pin mode from strap and enable bit
  function automatic mfp_pad_mode_e mfp_gio_mode(input logic card_mode,
                                                 input logic enable);
    mfp_pad_mode_e m;
    m = MFP_PAD_IN;
    if (card_mode && enable)
    begin
      m = MFP_PAD_OUT;
    end
    return m;
  endfunction : mfp_gio_mode

  // register bit that belongs to a pin lane
  function automatic int unsigned mfp_lane_bit(input int unsigned lane);
    int unsigned b;
    b = `MFP_GIO0_BIT;
    case (lane)
      `MFP_LANE_IO2: b = `MFP_GIO2_BIT;
      `MFP_LANE_IO3: b = `MFP_GIO3_BIT;
      `MFP_LANE_IO4: b = `MFP_GIO4_BIT;
      default:       b = `MFP_GIO0_BIT;
    endcase
    return b;
  endfunction : mfp_lane_bit
endpackage : mfp_pkg

/* mfp_stschg.sv */
// Purpose: status-change source and its unmask latch
// Assumes: wakeup level is synchronous to clock_i
// Notes:   a firmware write in the same cycle as a wakeup clear wins
`timescale 1ns/1ps
`default_nettype none
`include "mfp_params.svh"

module mfp_stschg
(
  input  wire logic                   clock_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   card_mode_i,
  input  wire logic                   func_sel_i,
  input  wire logic                   unmask_we_i,
  input  wire logic                   unmask_wdata_i,
  input  wire logic                   wakeup_i,
  output var  mfp_pkg::mfp_pad_mode_e mode_o,
  output var  logic                   drive_o
);

  logic unmask_reg;
  logic unmask_next;
  logic wakeup_d_reg;
  logic wakeup_fall;

  // ---------------------------------------------------------------
  // unmask latch
  // ---------------------------------------------------------------
  // a falling wakeup re-arms the mask for the next use
  always_comb
  begin
    wakeup_fall = wakeup_d_reg & ~wakeup_i;
    unmask_next = unmask_reg;
    if (unmask_we_i)
    begin
      unmask_next = unmask_wdata_i;                    // RULE15
    end
    else if (wakeup_fall)
    begin
      unmask_next = 1'b0;                              // RULE16
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      unmask_reg   <= `MFP_UNMASK_RST;
      wakeup_d_reg <= `MFP_BIT_RST;
    end
    else
    begin
      unmask_reg   <= unmask_next;
      wakeup_d_reg <= wakeup_i;
    end
  end

  // ---------------------------------------------------------------
  // pin source select
  // ---------------------------------------------------------------
  always_comb
  begin
    mode_o  = mfp_pkg::MFP_PAD_IN;                     // RULE13
    drive_o = 1'b0;
    if (card_mode_i)
    begin
      mode_o = mfp_pkg::MFP_PAD_OUT;                   // RULE13
      if (func_sel_i)
      begin
        drive_o = unmask_reg & wakeup_i;               // RULE14
      end
      else
      begin
        drive_o = ~unmask_reg;                         // RULE17
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_unmask_auto_clear: assert property ( // RULE16
    (wakeup_fall && !unmask_we_i) |=> !unmask_reg)
    else $error("unmask not cleared after wakeup clear");

  a_unmask_write_set: assert property ( // RULE15
    (unmask_we_i && unmask_wdata_i) |=> unmask_reg)
    else $error("unmask write of one lost");

endmodule : mfp_stschg

`default_nettype wire

/* tb_multi_function_pin_select.sv */
// Purpose: self-checking bench for the multi-function pin select
// Assumes: inputs change on the falling edge of clock_i
// Notes:   rows cover the mode table, hand tests cover reset and wakeup
`timescale 1ns/1ps
`default_nettype none

module tb_multi_function_pin_select;
  typedef struct packed
  {
    logic       s;
    logic [4:0] en;
    logic [4:0] dt;
    logic [3:0] bd;
    logic       f;
    logic       u;
    logic       w;
    logic       bs;
    logic [3:0] oe;
    logic [4:0] rd;
    logic       st;
  } mfp_row_s;

  logic       clock_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       strap = 1'b0;
  logic       en_we = 1'b0;
  logic [4:0] en_wd = 5'h00;
  logic       dt_we = 1'b0;
  logic [4:0] dt_wd = 5'h00;
  logic       fn_we = 1'b0;
  logic       fn = 1'b0;
  logic       um_we = 1'b0;
  logic       um_wd = 1'b0;
  logic       wake = 1'b0;
  logic [3:0] bd = 4'h0;
  logic       bs = 1'b0;
  logic [4:0] en_o;
  logic [4:0] rd_o;
  logic       um_o;
  logic       fn_o;
  logic [3:0] pin_o;
  logic [3:0] oe_o;
  logic       st_o;
  logic       st_oe_o;
  logic       la19;
  logic       sa16;
  logic       la17;
  logic       rf;
  logic       bale;
  logic [3:0] lvl;
  logic       st_lvl;
  int         fail_count = 0;
  int         checked = 0;
  mfp_row_s   r;
  mfp_row_s   rows [5] = '{
    '{1'b0, 5'h1d, 5'h1d, 4'ha, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 5'h14, 1'b1},
    '{1'b1, 5'h00, 5'h1d, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 5'h09, 1'b1},
    '{1'b1, 5'h1d, 5'h05, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hf, 5'h05, 1'b0},
    '{1'b1, 5'h0c, 5'h10, 4'hf, 1'b1, 1'b1, 1'b1, 1'b0, 4'h6, 5'h11, 1'b1},
    '{1'b1, 5'h13, 5'h1f, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h9, 5'h11, 1'b0}};

  // ---------------------------------------------------------------
  // clock, design and board
  // ---------------------------------------------------------------
  always #50 clock_i = ~clock_i;

  mfp_pin_mux uut
  (
    .clock_i                         (clock_i),
    .arst_n_i                        (arst_n_i),
    .host_bus_type_strap_i           (strap),
    .general_io_enable_we_i          (en_we),
    .general_io_enable_wdata_i       (en_wd),
    .general_io_data_we_i            (dt_we),
    .general_io_data_wdata_i         (dt_wd),
    .pin_function_we_i               (fn_we),
    .status_change_function_select_i (fn),
    .status_change_unmask_we_i       (um_we),
    .status_change_unmask_wdata_i    (um_wd),
    .card_wakeup_i                   (wake),
    .general_io_pin_i                (lvl),
    .status_change_pin_i             (st_lvl),
    .general_io_enable_o             (en_o),
    .general_io_data_bits_o          (rd_o),
    .status_change_function_select_o (fn_o),
    .status_change_unmask_o          (um_o),
    .general_io_pin_o                (pin_o),
    .general_io_pin_oe_o             (oe_o),
    .status_change_pin_o             (st_o),
    .status_change_pin_oe_o          (st_oe_o),
    .isa_la19_o                      (la19),
    .isa_sa16_o                      (sa16),
    .isa_la17_o                      (la17),
    .isa_refresh_o                   (rf),
    .isa_bale_o                      (bale)
  );

  mfp_board board
  (
    .dev_pin_i   (pin_o),
    .dev_oe_i    (oe_o),
    .dev_st_i    (st_o),
    .dev_st_oe_i (st_oe_o),
    .board_i     (bd),
    .board_st_i  (bs),
    .level_o     (lvl),
    .st_level_o  (st_lvl)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one write cycle, then four edges so pins and readback settle
  task automatic drive(input mfp_row_s d, input logic wu);
    @(negedge clock_i);
    strap = d.s;
    en_wd = d.en;
    dt_wd = d.dt;
    fn = d.f;
    um_wd = d.u;
    wake = d.w;
    bd = d.bd;
    bs = d.bs;
    en_we = 1'b1;
    dt_we = 1'b1;
    fn_we = 1'b1;
    um_we = wu;
    @(negedge clock_i);
    en_we = 1'b0;
    dt_we = 1'b0;
    fn_we = 1'b0;
    um_we = 1'b0;
    repeat (4) @(negedge clock_i);
  endtask : drive

  task automatic close_out;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // watchdog: the whole run needs well under 200 cycles
  // ---------------------------------------------------------------
  initial
  begin
    #(100 * 2000);
    fail_count++;
    close_out();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(negedge clock_i);
    chk({1'b0, oe_o}, 5'h00);
    arst_n_i = 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      drive(r, 1'b1);
      chk(en_o, r.en & 5'h1d);
      chk({1'b0, oe_o}, {1'b0, r.oe});
      chk({1'b0, pin_o & oe_o},
          {1'b0, {r.dt[4], r.dt[3], r.dt[2], r.dt[0]} & r.oe});
      chk(rd_o, r.rd);
      chk({1'b0, la17, sa16, la19, rf},
          r.s ? 5'h00 : {1'b0, r.bd});
      chk({4'h0, st_oe_o}, {4'h0, r.s});
      chk({4'h0, bale}, {4'h0, ~r.s & r.bs});
      chk({4'h0, um_o}, {4'h0, ~r.st});
      chk({4'h0, fn_o}, {4'h0, r.f});
      chk({4'h0, st_o}, {4'h0, r.s & r.st});
    end
    // second reset in mid-run drops every pin to high impedance
    arst_n_i = 1'b0;
    #1;
    chk({oe_o, st_oe_o}, 5'h00);
    repeat (4) @(negedge clock_i);
    arst_n_i = 1'b1;
    // unmask, then let the wakeup bit fall: the unmask must clear
    r = rows[3];
    drive(r, 1'b1);
    chk({4'h0, um_o}, 5'h00);
    r.w = 1'b0;
    drive(r, 1'b0);
    chk({4'h0, um_o}, 5'h01);
    // wakeup returns without a fresh unmask write: stays masked
    r.w = 1'b1;
    drive(r, 1'b0);
    chk({4'h0, um_o}, 5'h01);
    close_out();
  end
endmodule : tb_multi_function_pin_select

`default_nettype wire
